// ### tld_defs.vh
// Constants for the triple line delay FIFO block
// What this block does
// - Three static mode pins pick one of five arrangements, highest pin most significant.
// - Arrangement 1: three independent FIFOs, 256K words deep, 8 bits wide.
// - Write enable low: store input word each write clock edge, advance write counter.
// - Write enable high: ignore write clock edges, store nothing, hold write counter.
// - Write reset low resets that FIFO's write counter to its start.
// - Read enable low: drive next word out each read clock edge, advance read counter.
// - Read enable high: no read, hold read counter, output bus floats.
// - Read reset low resets that FIFO's read counter to its start.
// - Arrangement 2: first read port reads all three FIFOs, advancing all read counters.
// - Arrangement 2: each upstream word is written downstream, second and third counters advance.
// - Arrangement 2: first read enable high freezes reads, chain writes, floats all outputs.
// - Arrangement 2: first read reset clears first read and both chained counters.
// - Cascaded lines are at most 256K words each.
// - Arrangement 3: first two FIFOs chained two lines, third FIFO independent.
// - Arrangement 3: first read enable high holds chain, floats both chained outputs.
// - Arrangement 3: first read reset clears first read and second write and read counters.
// - Arrangement 4: first 12-bit FIFO takes first byte high, second input low nibble.
// - Arrangement 4: second 12-bit FIFO takes third byte high, second input high nibble.
// - Arrangement 5: two 12-bit FIFOs chained, first word copied into second FIFO.
// - Arrangement 5: first read enable high leaves both chained FIFOs unread.
// - Arrangement 5: first read enable high floats outputs and blocks second FIFO writes.
// - Arrangement 5: first read reset clears first read and second write and read counters.
`ifndef TLD_DEFS_VH
`define TLD_DEFS_VH

`define TLD_ADDR_W        18
// Idle pin levels for the synchroniser: active-low controls reset high
`define TLD_SYNC_IDLE     45'h0000_001f_8fc0
`define TLD_MODE_INDEP8   3'h0
`define TLD_MODE_CHAIN3   3'h1
`define TLD_MODE_CHAIN2   3'h2
`define TLD_MODE_INDEP12  3'h3
`define TLD_MODE_CHAIN12  3'h4

`define TLD_OFS_CTRL      8'h00
`define TLD_OFS_STATUS    8'h04
`define TLD_CTRL_OVR_BIT  0
`define TLD_CTRL_MODE_LSB 1
`define TLD_CTRL_RESET    4'h0

`endif

// ### tld_fifo_top.v
// Triple 256K-word line delay FIFO with mode select and Wishbone control
//
// Chosen here: the Wishbone register port and the register offsets.
`timescale 1ns/10ps
`include "tld_defs.vh"

module tld_fifo_top #(
  parameter AW = `TLD_ADDR_W
) (
  input  wire        ref_clk_i,
  input  wire        rst_n_i,
  input  wire [2:0]  mode_sel_i,
  input  wire        first_write_clock_i,
  input  wire        first_write_enable_n_i,
  input  wire        first_write_reset_n_i,
  input  wire        first_read_clock_i,
  input  wire        first_read_enable_n_i,
  input  wire        first_read_reset_n_i,
  input  wire        second_write_clock_i,
  input  wire        second_write_enable_n_i,
  input  wire        second_write_reset_n_i,
  input  wire        second_read_clock_i,
  input  wire        second_read_enable_n_i,
  input  wire        second_read_reset_n_i,
  input  wire        third_write_clock_i,
  input  wire        third_write_enable_n_i,
  input  wire        third_write_reset_n_i,
  input  wire        third_read_clock_i,
  input  wire        third_read_enable_n_i,
  input  wire        third_read_reset_n_i,
  input  wire [7:0]  first_data_in_i,
  input  wire [7:0]  second_data_in_i,
  input  wire [7:0]  third_data_in_i,
  output wire [7:0]  first_data_out_o,
  output wire [7:0]  first_data_oe_o,
  output wire [7:0]  second_data_out_o,
  output wire [7:0]  second_data_oe_o,
  output wire [7:0]  third_data_out_o,
  output wire [7:0]  third_data_oe_o,
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [7:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output wire [31:0] wb_dat_o,
  output wire        wb_ack_o
);

  // Raw pin bundle: every pin is outside this clock's domain
  wire [44:0] raw_pins;
  reg  [44:0] sync1_q;
  reg  [44:0] sync2_q;
  reg  [5:0]  clk_prev_q;

  assign raw_pins = {third_data_in_i, second_data_in_i, first_data_in_i,
                     third_read_reset_n_i, second_read_reset_n_i, first_read_reset_n_i,
                     third_read_enable_n_i, second_read_enable_n_i, first_read_enable_n_i,
                     third_read_clock_i, second_read_clock_i, first_read_clock_i,
                     third_write_reset_n_i, second_write_reset_n_i, first_write_reset_n_i,
                     third_write_enable_n_i, second_write_enable_n_i, first_write_enable_n_i,
                     third_write_clock_i, second_write_clock_i, first_write_clock_i,
                     mode_sel_i};

  wire [2:0]  pin_mode = sync2_q[2:0];
  wire [2:0]  wck_s    = sync2_q[5:3];
  wire [2:0]  we_n_s   = sync2_q[8:6];
  wire [2:0]  wres_n_s = sync2_q[11:9];
  wire [2:0]  rck_s    = sync2_q[14:12];
  wire [2:0]  re_n_s   = sync2_q[17:15];
  wire [2:0]  rres_n_s = sync2_q[20:18];
  wire [23:0] din_s    = sync2_q[44:21];

  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      // Idle levels, so no false enable or reset follows release
      sync1_q    <= `TLD_SYNC_IDLE;
      sync2_q    <= `TLD_SYNC_IDLE;
      clk_prev_q <= 6'h0;
    end else begin
      sync1_q    <= raw_pins;
      sync2_q    <= sync1_q;
      clk_prev_q <= {rck_s, wck_s};
    end
  end

  // Port edge events; controls and data are sampled at the same edge
  wire [2:0] wck_rise = wck_s & ~clk_prev_q[2:0];
  wire [2:0] rck_rise = rck_s & ~clk_prev_q[5:3];
  wire [2:0] wgo = wck_rise & ~we_n_s & wres_n_s;
  wire [2:0] wrs = wck_rise & ~wres_n_s;
  wire [2:0] rgo = rck_rise & ~re_n_s & rres_n_s;
  wire [2:0] rrs = rck_rise & ~rres_n_s;

  // Wishbone control: software may override the mode pins
  reg  [3:0]  ctrl_q;
  reg  [31:0] wb_dat_q;
  reg         wb_ack_q;
  reg  [2:0]  mode_q;
  wire        wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_q;

  // Mode decode, highest pin most significant
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mode_q <= `TLD_MODE_INDEP8;
    end else if (ctrl_q[`TLD_CTRL_OVR_BIT]) begin
      mode_q <= ctrl_q[`TLD_CTRL_MODE_LSB +: 3];
    end else begin
      mode_q <= pin_mode;
    end
  end

  // Banks: 0 = first byte, 1 = low nibble, 2 = high nibble, 3 = third byte
  wire [31:0] rdw;
  reg  [3:0]  wev;
  reg  [3:0]  wrst;
  reg  [3:0]  rev;
  reg  [3:0]  rrst;
  reg  [3:0]  roe;
  reg  [31:0] wd;

  always @* begin
    // Independent 8-bit FIFOs; modes 6 to 8 fall back here too
    wev  = {wgo[2], wgo[1], wgo[1], wgo[0]};
    wrst = {wrs[2], wrs[1], wrs[1], wrs[0]};
    rev  = {rgo[2], rgo[1], rgo[1], rgo[0]};
    rrst = {rrs[2], rrs[1], rrs[1], rrs[0]};
    roe  = {~re_n_s[2], ~re_n_s[1], ~re_n_s[1], ~re_n_s[0]};
    wd   = {din_s[23:16], 4'h0, din_s[15:12], 4'h0, din_s[11:8], din_s[7:0]};
    case (mode_q)
      `TLD_MODE_CHAIN3: begin
        // First read port drives every read and downstream write
        wev[3:1]  = {3{rgo[0]}};
        wrst[3:1] = {3{rrs[0]}};
        rev       = {4{rgo[0]}};
        rrst      = {4{rrs[0]}};
        roe       = {4{~re_n_s[0]}};
        wd[31:8]  = {rdw[19:16], rdw[11:8], 4'h0, rdw[7:4], 4'h0, rdw[3:0]};
      end
      `TLD_MODE_CHAIN2: begin
        wev[2:1]  = {2{rgo[0]}};
        wrst[2:1] = {2{rrs[0]}};
        rev[2:0]  = {3{rgo[0]}};
        rrst[2:0] = {3{rrs[0]}};
        roe[2:0]  = {3{~re_n_s[0]}};
        wd[23:8]  = {4'h0, rdw[7:4], 4'h0, rdw[3:0]};
      end
      `TLD_MODE_INDEP12: begin
        // Two 12-bit FIFOs; third port controls are unused
        wev  = {wgo[1], wgo[1], wgo[0], wgo[0]};
        wrst = {wrs[1], wrs[1], wrs[0], wrs[0]};
        rev  = {rgo[1], rgo[1], rgo[0], rgo[0]};
        rrst = {rrs[1], rrs[1], rrs[0], rrs[0]};
        roe  = {~re_n_s[1], ~re_n_s[1], ~re_n_s[0], ~re_n_s[0]};
      end
      `TLD_MODE_CHAIN12: begin
        // First 12-bit word copied into second 12-bit FIFO
        wev  = {rgo[0], rgo[0], wgo[0], wgo[0]};
        wrst = {rrs[0], rrs[0], wrs[0], wrs[0]};
        rev  = {4{rgo[0]}};
        rrst = {4{rrs[0]}};
        roe  = {4{~re_n_s[0]}};
        wd[31:16] = {rdw[7:0], 4'h0, rdw[11:8]};
      end
      default: begin
        wev = wev;
      end
    endcase
  end

  // Bank storage: address wraps at the line length
  wire [31:0] bank_out;
  wire [3:0]  bank_oe;

  genvar gb;
  generate
    for (gb = 0; gb < 4; gb = gb + 1) begin : g_bank
      reg [7:0]    mem [0:(1<<AW)-1];
      reg [AW-1:0] wp_q;
      reg [AW-1:0] rp_q;
      reg [7:0]    out_q;
      reg          oe_q;
      assign rdw[gb*8 +: 8]      = mem[rp_q];
      assign bank_out[gb*8 +: 8] = out_q;
      assign bank_oe[gb]         = oe_q;

      always @(posedge ref_clk_i) begin
        if (wev[gb] && !wrst[gb]) begin
          mem[wp_q] <= wd[gb*8 +: 8];
        end
      end

      always @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          wp_q           <= {AW{1'b0}};
          rp_q           <= {AW{1'b0}};
          out_q          <= 8'h0;
          oe_q           <= 1'b0;
        end else begin
          oe_q          <= roe[gb];
          if (wrst[gb]) begin
            wp_q <= {AW{1'b0}};
          end else if (wev[gb]) begin
            wp_q <= wp_q + 1'b1;
          end
          if (rrst[gb]) begin
            rp_q <= {AW{1'b0}};
          end else if (rev[gb]) begin
            rp_q           <= rp_q + 1'b1;
            out_q          <= mem[rp_q];
          end
        end
      end
    end
  endgenerate

  // Output pins map nibble banks onto the second bus
  reg [7:0] q1_q;
  reg [7:0] q2_q;
  reg [7:0] q3_q;
  reg [7:0] oe1_q;
  reg [7:0] oe2_q;
  reg [7:0] oe3_q;

  always @* begin
    q1_q  = bank_out[7:0];
    q2_q  = {bank_out[19:16], bank_out[11:8]};
    q3_q  = bank_out[31:24];
    oe1_q = {8{bank_oe[0]}};
    oe2_q = {{4{bank_oe[2]}}, {4{bank_oe[1]}}};
    oe3_q = {8{bank_oe[3]}};
  end

  assign first_data_out_o  = q1_q;
  assign second_data_out_o = q2_q;
  assign third_data_out_o  = q3_q;
  assign first_data_oe_o   = oe1_q;
  assign second_data_oe_o  = oe2_q;
  assign third_data_oe_o   = oe3_q;

  // Wishbone slave: one wait state, unmapped reads return zero
  always @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl_q   <= `TLD_CTRL_RESET;
      wb_dat_q <= 32'h0;
      wb_ack_q <= 1'b0;
    end else begin
      wb_ack_q <= wb_req;
      wb_dat_q <= 32'h0;
      if (wb_req && wb_we_i && wb_sel_i[0] && wb_adr_i == `TLD_OFS_CTRL) begin
        ctrl_q <= wb_dat_i[3:0];
      end
      if (wb_req && !wb_we_i) begin
        case (wb_adr_i)
          `TLD_OFS_CTRL:   wb_dat_q <= {28'h0, ctrl_q};
          `TLD_OFS_STATUS: wb_dat_q <= {22'h0, bank_oe, pin_mode, mode_q};
          default:         wb_dat_q <= 32'h0;
        endcase
      end
    end
  end

  assign wb_dat_o = wb_dat_q;
  assign wb_ack_o = wb_ack_q;

endmodule

// ### tld_fifo_monitor.sv
// Port-level checks for the line delay FIFO block
`timescale 1ns/10ps
module tld_fifo_monitor (
  input wire       ref_clk_i,
  input wire       rst_n_i,
  input wire [2:0] mode_sel_i,
  input wire       first_read_enable_n_i,
  input wire       second_read_enable_n_i,
  input wire [7:0] first_data_out_o,
  input wire [7:0] first_data_oe_o,
  input wire [7:0] second_data_oe_o,
  input wire [7:0] third_data_oe_o,
  input wire       wb_cyc_i,
  input wire       wb_stb_i,
  input wire       wb_ack_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  // Six samples cover the two-stage sync plus the output register
  sequence s_off; first_read_enable_n_i[*6]; endsequence
  sequence s_on; (!first_read_enable_n_i)[*6]; endsequence
  sequence s_req; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
  property p_a_off; s_off |-> first_data_oe_o == 8'h00; endproperty
  property p_a_on; s_on |-> first_data_oe_o == 8'hff; endproperty
  property p_hold; s_off |=> $stable(first_data_out_o); endproperty
  property p_c_off;
    (mode_sel_i == 3'h1 && first_read_enable_n_i)[*6] |-> third_data_oe_o == 8'h00;
  endproperty
  property p_c_on;
    (mode_sel_i == 3'h1 && !first_read_enable_n_i)[*6] |-> third_data_oe_o == 8'hff;
  endproperty
  property p_split;
    (mode_sel_i == 3'h3 && !first_read_enable_n_i && second_read_enable_n_i)[*6]
      |-> second_data_oe_o == 8'h0f;
  endproperty
  property p_ack; s_req |=> wb_ack_o; endproperty
  property p_ack1; wb_ack_o |=> !wb_ack_o; endproperty
  a_a_off: assert property (p_a_off) else $error("first bus driven while idle");
  a_a_on: assert property (p_a_on) else $error("first bus floats while read");
  a_hold: assert property (p_hold) else $error("output moved without read");
  a_c_off: assert property (p_c_off) else $error("chain bus driven while idle");
  a_c_on: assert property (p_c_on) else $error("chain bus floats while read");
  a_split: assert property (p_split) else $error("split nibble enable wrong");
  a_ack: assert property (p_ack) else $error("no ack one cycle after request");
  a_ack1: assert property (p_ack1) else $error("ack longer than one cycle");
endmodule

bind tld_fifo_top tld_fifo_monitor tld_fifo_monitor_i (
  .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .mode_sel_i(mode_sel_i),
  .first_read_enable_n_i(first_read_enable_n_i),
  .second_read_enable_n_i(second_read_enable_n_i), .first_data_out_o(first_data_out_o),
  .first_data_oe_o(first_data_oe_o), .second_data_oe_o(second_data_oe_o),
  .third_data_oe_o(third_data_oe_o), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o));

// ### tld_link_partner.sv
// Port clock source of the far-side logic, still outside frames
`timescale 1ns/10ps
module tld_link_partner #(
  parameter PHASE = 7,
  parameter HALF  = 80
) (
  input  wire run_i,
  output reg  clk_o
);
  // Whole pulses only, so the sampler never sees a runt edge
  initial begin
    clk_o = 1'b0;
    #PHASE;
    forever begin
      #HALF;
      clk_o = run_i ? ~clk_o : 1'b0;
    end
  end
endmodule

// ### tld_testbench.sv
// Self-checking bench for the line delay FIFO, modes 1 to 5
`timescale 1ns/10ps
module testbench;
  reg        ref_clk, rst_n, run, cyc, stb, we;
  reg [2:0]  mode, wen, wrs, ren, rrs;
  reg [3:0]  sel;
  reg [7:0]  adr;
  reg [31:0] wdat, rd;
  reg [23:0] din, eq, eo;
  wire       wclk, rclk, ack;
  wire [23:0] q, oe;
  wire [31:0] wbq;
  int mismatches, samples_checked, cycles, m;
  int mem[6][64];
  int wp[3], rp[3];
  tld_fifo_top #(.AW(6)) tld_fifo_top_i (
    .ref_clk_i(ref_clk), .rst_n_i(rst_n), .mode_sel_i(mode),
    .first_write_clock_i(wclk), .second_write_clock_i(wclk), .third_write_clock_i(wclk),
    .first_write_enable_n_i(wen[0]), .second_write_enable_n_i(wen[1]),
    .third_write_enable_n_i(wen[2]), .first_write_reset_n_i(wrs[0]),
    .second_write_reset_n_i(wrs[1]), .third_write_reset_n_i(wrs[2]),
    .first_read_clock_i(rclk), .second_read_clock_i(rclk), .third_read_clock_i(rclk),
    .first_read_enable_n_i(ren[0]), .second_read_enable_n_i(ren[1]),
    .third_read_enable_n_i(ren[2]), .first_read_reset_n_i(rrs[0]),
    .second_read_reset_n_i(rrs[1]), .third_read_reset_n_i(rrs[2]),
    .first_data_in_i(din[7:0]), .second_data_in_i(din[15:8]), .third_data_in_i(din[23:16]),
    .first_data_out_o(q[7:0]), .second_data_out_o(q[15:8]), .third_data_out_o(q[23:16]),
    .first_data_oe_o(oe[7:0]), .second_data_oe_o(oe[15:8]), .third_data_oe_o(oe[23:16]),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(wbq), .wb_ack_o(ack));
  tld_link_partner #(.PHASE(3)) wr_link_i (.run_i(run), .clk_o(wclk));
  tld_link_partner #(.PHASE(47)) rd_link_i (.run_i(run), .clk_o(rclk));
  // Nibble n of the 24 data pins belongs to one FIFO word
  function automatic int own(int n);
    return (m >= 3) ? int'(n > 2) : n / 2;
  endfunction
  function automatic int ctl(int f);
    return (m == 1 || ((m == 2 || m == 4) && f < 2)) ? 0 : f;
  endfunction
  function automatic int src(int n);
    return (m == 4) ? ((n == 3) ? 2 : n - 4) : n - 2;
  endfunction
  // Unused ports stay parked high
  function automatic logic [2:0] act();
    return m == 0 ? 3'h7 : m == 2 ? 3'h5 : m == 3 ? 3'h3 : 3'h1;
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    samples_checked++;
    if (seen !== want) begin
      mismatches++;
      $display("[FAIL] t=%0t seen %h want %h", $time, seen, want);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    {cyc, stb, we, adr, wdat, sel} <= {2'b11, w, a, d, 4'hf};
    do begin
      @(posedge ref_clk);
    end while (ack !== 1'b1);
    rd = wbq;
    {cyc, stb} <= 2'b00;
  endtask
  task automatic tick(input bit rdp, input logic [2:0] en, input logic [2:0] rs);
    int rv[6];
    int f;
    logic [23:0] d;
    d = $urandom;
    for (int n = 0; n < 6; n++) if (!act()[own(n)]) d[4*n+:4] = 4'h0;
    if (rdp) @(negedge rclk); else @(negedge wclk);
    @(posedge ref_clk);
    if (rdp) {ren, rrs} <= {en, rs};
    else {wen, wrs, din} <= {en, rs, d};
    if (rdp) @(posedge rclk); else @(posedge wclk);
    repeat (6) @(posedge ref_clk);
    for (int n = 0; n < 6; n++) begin
      f = own(n);
      rv[n] = mem[n][rp[f]];
      if (rdp) begin
        eo[4*n+:4] = en[ctl(f)] ? 4'h0 : 4'hf;
        if (rs[ctl(f)] && !en[ctl(f)]) eq[4*n+:4] = rv[n][3:0];
        if (ctl(f) != f && rs[0] && !en[0]) mem[n][wp[f]] = rv[src(n)];
      end else if (ctl(f) == f && rs[f] && !en[f]) mem[n][wp[f]] = d[4*n+:4];
    end
    for (f = 0; f < 3; f++) begin
      if (rdp && !rs[ctl(f)]) begin
        rp[f] = 0;
        if (ctl(f) != f) wp[f] = 0;
      end else if (rdp && !en[ctl(f)]) begin
        rp[f] = (rp[f] + 1) % 64;
        if (ctl(f) != f) wp[f] = (wp[f] + 1) % 64;
      end else if (!rdp && ctl(f) == f && !rs[f]) wp[f] = 0;
      else if (!rdp && ctl(f) == f && !en[f]) wp[f] = (wp[f] + 1) % 64;
    end
    if (rdp) chk({8'h00, q}, {8'h00, eq});
    if (rdp) chk({8'h00, oe}, {8'h00, eo});
    // Port clocks run free: park the port so later edges do nothing
    if (rdp) {ren, rrs} <= 6'h3f;
    else {wen, wrs} <= 6'h3f;
  endtask
  task automatic close_out();
    $display("checked %0d, mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      close_out();
    end
  end
  initial begin
    {rst_n, run, cyc, stb, we, adr, wdat, sel, din, eq, eo} = '0;
    {mode, wen, wrs, ren, rrs} = 15'h0fff;
    m = 0;
    void'($urandom(22160));
    repeat (10) @(posedge ref_clk);
    {rst_n, run} <= 2'b11;
    wb(0, 8'h00, 0);
    chk(rd, 0);
    tick(0, 3'h7, 3'h0);
    tick(1, 3'h7, 3'h0);
    repeat (64) tick(0, 3'h0, 3'h7);
    for (int k = 0; k < 5; k++) begin
      m = k;
      mode <= k[2:0];
      repeat (8) @(posedge ref_clk);
      wb(0, 8'h04, 0);
      chk({29'h0, rd[2:0]}, k);
      tick(0, 3'h7, ~act());
      tick(1, 3'h7, ~act());
      repeat (20) tick(0, ~act() | 3'($urandom), 3'h7);
      repeat (24) tick(1, ~act() | 3'($urandom), 3'h7);
      tick(1, 3'h7, ~act());
      repeat (8) tick(1, ~act(), 3'h7);
      $display("mode %0d done, mismatches %0d", k + 1, mismatches);
    end
    m = 0;
    mode <= 3'h0;
    wb(1, 8'h00, 32'h5);
    wb(0, 8'h04, 0);
    chk({29'h0, rd[2:0]}, 2);
    wb(0, 8'h00, 0);
    chk(rd, 5);
    wb(1, 8'h08, 32'hffff_ffff);
    wb(0, 8'h08, 0);
    chk(rd, 0);
    wb(1, 8'h00, 0);
    $display("register test done, mismatches %0d", mismatches);
    run <= 1'b0;
    close_out();
  end
endmodule
